// ==== sim/led_fault_sequencer_props.sv ====
`timescale 1ns/100ps
module led_fault_sequencer_props #(
	parameter int unsigned HICCUP_TICKS = 8,
	parameter int unsigned OSC_DIV = 4
)(
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic TEMP_TRIP_I,
	input wire logic OV_TRIP_I,
	input wire logic CTRL_ABOVE_HI_I,
	input wire logic CTRL_BELOW_LO_I,
	input wire logic DIM_I,
	input wire logic PWM_I,
	input wire logic SWITCH_GATE_DRIVE_O,
	input wire logic DIM_GATE_DRIVE_N_O,
	input wire logic FAULT_INDICATOR_N_O,
	input wire logic FAULT_INDICATOR_N_OE_O,
	input wire logic EA_CONNECT_O,
	input wire logic REF_INTERNAL_O,
	input wire logic HICCUP_ACTIVE_O
);
	// slack of one tick: timer starts off the tick grid
	localparam int HIC_MIN = (HICCUP_TICKS - 1) * OSC_DIV;
	localparam int HIC_MAX = (HICCUP_TICKS + 1) * OSC_DIV + 2;
	logic [15:0] hic_cnt_r;
	logic [15:0] hic_cnt_nxt;
	always_comb hic_cnt_nxt = HICCUP_ACTIVE_O ? hic_cnt_r + 16'h0001 : 16'h0000;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
		if (SYS_RST_I) hic_cnt_r <= 16'h0000;
		else hic_cnt_r <= hic_cnt_nxt;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	sequence s_off;
		!SWITCH_GATE_DRIVE_O && DIM_GATE_DRIVE_N_O;
	endsequence
	sequence s_hic_end;
		$fell(HICCUP_ACTIVE_O);
	endsequence
	property p_therm;
		TEMP_TRIP_I[*8] |-> s_off ##0 !FAULT_INDICATOR_N_OE_O;
	endproperty
	property p_ov;
		OV_TRIP_I[*8] |-> s_off ##0 !FAULT_INDICATOR_N_OE_O;
	endproperty
	property p_dim;
		!DIM_I[*8] |-> DIM_GATE_DRIVE_N_O && !EA_CONNECT_O;
	endproperty
	property p_hic;
		HICCUP_ACTIVE_O[*2] |-> s_off ##0 !(EA_CONNECT_O || FAULT_INDICATOR_N_OE_O);
	endproperty
	property p_fdrv;
		FAULT_INDICATOR_N_O == 1'b0;
	endproperty
	property p_ref_hi;
		(CTRL_ABOVE_HI_I && !CTRL_BELOW_LO_I)[*8] |-> REF_INTERNAL_O;
	endproperty
	property p_ref_lo;
		(CTRL_BELOW_LO_I && !CTRL_ABOVE_HI_I)[*8] |-> !REF_INTERNAL_O;
	endproperty
	property p_pwm_off;
		!PWM_I[*8] |-> !SWITCH_GATE_DRIVE_O;
	endproperty
	// pwm pin settled for two samples reaches the gate four edges later
	property p_pwm_on;
		!DIM_GATE_DRIVE_N_O && $past(PWM_I, 4) == $past(PWM_I, 5) |->
			SWITCH_GATE_DRIVE_O == $past(PWM_I, 4);
	endproperty
	property p_hic_max;
		HICCUP_ACTIVE_O |-> hic_cnt_r <= HIC_MAX;
	endproperty
	property p_hic_min;
		s_hic_end |-> hic_cnt_r >= HIC_MIN;
	endproperty
	property p_retry;
		s_hic_end |-> !FAULT_INDICATOR_N_OE_O[*8];
	endproperty
	a_therm: assert property (p_therm) else $error("thermal off");
	a_ov: assert property (p_ov) else $error("ov off");
	a_dim: assert property (p_dim) else $error("dim off");
	a_hic: assert property (p_hic) else $error("hiccup outs");
	a_fdrv: assert property (p_fdrv) else $error("pin drive");
	a_ref_hi: assert property (p_ref_hi) else $error("ref int");
	a_ref_lo: assert property (p_ref_lo) else $error("ref pin");
	a_pwm_off: assert property (p_pwm_off) else $error("gate on");
	a_pwm_on: assert property (p_pwm_on) else $error("gate follow");
	a_hic_max: assert property (p_hic_max) else $error("hiccup long");
	a_hic_min: assert property (p_hic_min) else $error("hiccup short");
	a_retry: assert property (p_retry) else $error("retry latch");
endmodule
bind led_fault_sequencer led_fault_sequencer_props #(
	.HICCUP_TICKS(HICCUP_TICKS),
	.OSC_DIV(OSC_DIV)
) u_props (
	.CORE_CLK_I(CORE_CLK_I),
	.SYS_RST_I(SYS_RST_I),
	.TEMP_TRIP_I(TEMP_TRIP_I),
	.OV_TRIP_I(OV_TRIP_I),
	.CTRL_ABOVE_HI_I(CTRL_ABOVE_HI_I),
	.CTRL_BELOW_LO_I(CTRL_BELOW_LO_I),
	.DIM_I(DIM_I),
	.PWM_I(PWM_I),
	.SWITCH_GATE_DRIVE_O(SWITCH_GATE_DRIVE_O),
	.DIM_GATE_DRIVE_N_O(DIM_GATE_DRIVE_N_O),
	.FAULT_INDICATOR_N_O(FAULT_INDICATOR_N_O),
	.FAULT_INDICATOR_N_OE_O(FAULT_INDICATOR_N_OE_O),
	.EA_CONNECT_O(EA_CONNECT_O),
	.REF_INTERNAL_O(REF_INTERNAL_O),
	.HICCUP_ACTIVE_O(HICCUP_ACTIVE_O)
);

// ==== sim/led_string_model.sv ====
`timescale 1ns/100ps
module led_string_model (
	input wire logic sw_gate_i,
	input wire logic dim_gate_n_i,
	input wire logic flt_n_i,
	input wire logic flt_n_oe_i,
	output logic flt_line_o,
	output logic led_lit_o
);
	assign flt_line_o = flt_n_oe_i ? 1'b1 : flt_n_i;
	assign led_lit_o = !dim_gate_n_i && sw_gate_i !== 1'bx;
endmodule

// ==== sim/test_led_fault_sequencer.sv ====
`timescale 1ns/100ps
module test_led_fault_sequencer import fault_seq_pkg::*;;
	localparam int HT = 8;
	localparam int PT = 8;
	localparam int OD = 4;
	logic clk = 0, rst = 1, tt = 0, tc = 0, ot = 0, orl = 0, bs = 0, bb = 0;
	logic hi = 1, lo = 0, dim = 1, pwm = 0, mbb = 0;
	logic sw, dn, fo, foe, ea, rf, hc, fl, lit, pf = 1;
	logic [15:0] r = 16'h0005;
	logic q[$];
	int err_count = 0, checked = 0, n;
	initial forever #2.5 clk = ~clk;
	led_fault_sequencer #(.HICCUP_TICKS(HT), .PERSIST_TICKS(PT),
		.OSC_DIV(OD)) u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst),
		.TEMP_TRIP_I(tt), .TEMP_COOLED_I(tc), .OV_TRIP_I(ot),
		.OV_RELEASE_I(orl), .BOOST_SHORT_I(bs), .BB_SHORT_I(bb),
		.CTRL_ABOVE_HI_I(hi), .CTRL_BELOW_LO_I(lo), .DIM_I(dim),
		.PWM_I(pwm), .MODE_BUCK_BOOST_I(mbb), .FAULT_INDICATOR_N_I(fl),
		.SWITCH_GATE_DRIVE_O(sw), .DIM_GATE_DRIVE_N_O(dn),
		.FAULT_INDICATOR_N_O(fo), .FAULT_INDICATOR_N_OE_O(foe),
		.EA_CONNECT_O(ea), .REF_INTERNAL_O(rf), .HICCUP_ACTIVE_O(hc));
	led_string_model u_load (.sw_gate_i(sw), .dim_gate_n_i(dn),
		.flt_n_i(fo), .flt_n_oe_i(foe), .flt_line_o(fl), .led_lit_o(lit));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task cmp(input logic [5:0] g, input logic [5:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task summarize;
		$display("errors=%0d checks=%0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// bounded wait on fault line or hiccup flag
	task wt(input bit h, input logic v, input int lim);
		n = 0;
		while ((h ? hc : fl) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) begin
			cmp({5'h0, ~v}, {5'h0, v});
			summarize;
		end
	endtask
	task pin(input int k, input logic v);
		case (k)
			0: tt = v;
			1: tc = v;
			2: ot = v;
			default: orl = v;
		endcase
	endtask
	always @(negedge clk) begin
		r <= lfsr(r);
		pwm <= r[0];
	end
	// every fault pin edge must have been announced
	always @(negedge clk) if (!rst && fl !== pf) begin
		pf = fl;
		cmp({5'h0, fl}, {5'h0, q.size() ? q.pop_front() : ~fl});
	end
	initial begin
		repeat (3) @(negedge clk);
		rst = 0;
		repeat (10) @(negedge clk);
		for (int i = 0; i < 2; i++) begin
			q.push_back(0);
			q.push_back(1);
			pin(2 * i, 1);
			repeat (12) @(negedge clk);
			cmp({sw, dn, foe, ea, rf, hc}, 6'h16);
			pin(2 * i, 0);
			repeat (12) @(negedge clk);
			cmp({5'h0, fl}, 6'h00);
			pin(2 * i + 1, 1);
			wt(0, 1, 20);
			pin(2 * i + 1, 0);
		end
		dim = 0;
		repeat (10) @(negedge clk);
		cmp({sw, dn, foe, ea, rf, hc}, 6'h1a);
		cmp({5'h0, lit}, 6'h00);
		dim = 1;
		hi = 0;
		lo = 1;
		repeat (10) @(negedge clk);
		cmp({5'h0, rf}, 6'h00);
		lo = 0;
		repeat (10) @(negedge clk);
		cmp({5'h0, rf}, 6'h00);
		hi = 1;
		repeat (10) @(negedge clk);
		cmp({5'h0, rf}, 6'h01);
		cmp({5'h0, lit}, 6'h01);
		q.push_back(0);
		bs = 1;
		wt(1, 1, 300);
		cmp({5'h0, n >= QUAL_CYC}, 6'h01);
		bs = 0;
		repeat (3) @(negedge clk);
		cmp({sw, dn, foe, ea, rf, hc}, 6'h13);
		wt(1, 0, HT * OD + 3 * OD);
		q.push_back(1);
		wt(0, 1, RETRY_CYC + 100);
		cmp({5'h0, n >= RETRY_CYC - 2}, 6'h01);
		mbb = 1;
		repeat (400) begin
			@(negedge clk);
			bb = r[1] & r[2];
		end
		bb = 0;
		repeat (PT * OD + 20) @(negedge clk);
		q.push_back(0);
		bb = 1;
		wt(0, 0, 2 * PT * OD + 40);
		cmp({5'h0, n >= PT * OD - OD}, 6'h01);
		q.push_back(1);
		bb = 0;
		wt(0, 1, 2 * PT * OD + 40);
		cmp({5'h0, n >= PT * OD - OD}, 6'h01);
		repeat (5) @(negedge clk);
		cmp({5'h0, q.size() == 0}, 6'h01);
		// boost short sense is ignored in buck-boost mode
		bs = 1;
		repeat (300) @(negedge clk);
		cmp({5'h0, hc}, 6'h00);
		bs = 0;
		summarize;
	end
	initial begin
		#400000;
		err_count++;
		summarize;
	end
endmodule

// ==== verilog/fault_seq_pkg.sv ====
package fault_seq_pkg;

	// core clock
	localparam int unsigned CORE_CLK_MHZ = 200;

	// analog trip points handled by the comparators in front of this block
	localparam int unsigned TEMP_TRIP_C = 160;
	localparam int unsigned TEMP_HYST_C = 10;
	localparam int unsigned OV_TRIP_MV = 1230;
	localparam int unsigned OV_HYST_MV = 70;
	localparam int unsigned BOOST_SHORT_MV = 300;
	localparam int unsigned BB_MARGIN_MV = 1500;
	localparam int unsigned CTRL_HI_MV = 1230;
	localparam int unsigned CTRL_LO_MV = 1200;
	localparam int unsigned FULL_SCALE_MV = 200;

	// boost short qualification, least time, rounded up
	localparam int unsigned QUAL_TIME_NS = 1000;
	localparam int unsigned QUAL_CYC = (QUAL_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int unsigned QUAL_W = 8;

	// retry window after hiccup, rounded up
	localparam int unsigned RETRY_TIME_NS = 20000;
	localparam int unsigned RETRY_CYC = (RETRY_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int unsigned RETRY_W = 12;

	// oscillator ticks
	localparam int unsigned HICCUP_TICKS_DEF = 8192;
	localparam int unsigned PERSIST_TICKS_DEF = 8192;
	localparam int unsigned TICK_W = 14;
	localparam int unsigned OSC_DIV_DEF = 1000;
	localparam int unsigned OSC_W = 16;

	// synchronised pin vector layout
	localparam int unsigned PIN_W = 11;
	localparam int unsigned P_TEMP_TRIP = 0;
	localparam int unsigned P_TEMP_COOL = 1;
	localparam int unsigned P_OV_TRIP = 2;
	localparam int unsigned P_OV_REL = 3;
	localparam int unsigned P_BOOST_SHORT = 4;
	localparam int unsigned P_BB_SHORT = 5;
	localparam int unsigned P_CTRL_HI = 6;
	localparam int unsigned P_CTRL_LO = 7;
	localparam int unsigned P_DIM = 8;
	localparam int unsigned P_PWM = 9;
	localparam int unsigned P_MODE_BB = 10;

	// values after reset
	localparam logic REF_INT_RST = 1'b1;
	localparam logic [PIN_W-1:0] PIN_RST = 11'h000;

	typedef enum logic [1:0] {ST_RUN, ST_HICCUP, ST_RETRY} hiccup_state_t;

endpackage

// ==== verilog/led_fault_sequencer.sv ====
`timescale 1ns/100ps
module led_fault_sequencer import fault_seq_pkg::*; #(
	parameter bit HICCUP_EN = 1'b1,
	parameter int unsigned HICCUP_TICKS = HICCUP_TICKS_DEF,
	parameter int unsigned PERSIST_TICKS = PERSIST_TICKS_DEF,
	parameter int unsigned OSC_DIV = OSC_DIV_DEF
)(
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic TEMP_TRIP_I,
	input wire logic TEMP_COOLED_I,
	input wire logic OV_TRIP_I,
	input wire logic OV_RELEASE_I,
	input wire logic BOOST_SHORT_I,
	input wire logic BB_SHORT_I,
	input wire logic CTRL_ABOVE_HI_I,
	input wire logic CTRL_BELOW_LO_I,
	input wire logic DIM_I,
	input wire logic PWM_I,
	input wire logic MODE_BUCK_BOOST_I,
	input wire logic FAULT_INDICATOR_N_I,
	output logic SWITCH_GATE_DRIVE_O,
	output logic DIM_GATE_DRIVE_N_O,
	output logic FAULT_INDICATOR_N_O,
	output logic FAULT_INDICATOR_N_OE_O,
	output logic EA_CONNECT_O,
	output logic REF_INTERNAL_O,
	output logic HICCUP_ACTIVE_O
);

	// pin synchronisers: s1 feeds s2 only, filter looks at s2 and s3
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] s1_r;
	logic [PIN_W-1:0] s2_r;
	logic [PIN_W-1:0] s3_r;
	logic [PIN_W-1:0] filt_r;
	logic [PIN_W-1:0] filt_nxt;

	// the readback of the fault pin is not needed by any decision here
	logic unused_fault_pin;
	assign unused_fault_pin = FAULT_INDICATOR_N_I;

	assign pins = {MODE_BUCK_BOOST_I, PWM_I, DIM_I, CTRL_BELOW_LO_I,
		CTRL_ABOVE_HI_I, BB_SHORT_I, BOOST_SHORT_I, OV_RELEASE_I,
		OV_TRIP_I, TEMP_COOLED_I, TEMP_TRIP_I};

	always_comb begin
		filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
	end

	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			s1_r <= PIN_RST;
			s2_r <= PIN_RST;
			s3_r <= PIN_RST;
			filt_r <= PIN_RST;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= filt_nxt;
		end
	end

	logic mode_bb;
	logic dim_on;
	logic pwm_req;
	assign mode_bb = filt_r[P_MODE_BB];
	assign dim_on = filt_r[P_DIM];
	assign pwm_req = filt_r[P_PWM];

	// oscillator tick divider
	logic [OSC_W-1:0] osc_cnt_r;
	logic [OSC_W-1:0] osc_cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb begin
		if (osc_cnt_r == OSC_W'(OSC_DIV - 1)) begin
			osc_cnt_nxt = '0;
			tick_nxt = 1'b1;
		end else begin
			osc_cnt_nxt = osc_cnt_r + OSC_W'(1);
			tick_nxt = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			osc_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			osc_cnt_r <= osc_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// hysteretic conditions; a trip seen with its release wins
	logic therm_r;
	logic therm_nxt;
	logic ov_r;
	logic ov_nxt;
	logic ref_int_r;
	logic ref_int_nxt;

	always_comb begin
		therm_nxt = therm_r;
		if (filt_r[P_TEMP_TRIP]) begin
			therm_nxt = 1'b1;
		end else if (filt_r[P_TEMP_COOL]) begin
			therm_nxt = 1'b0;
		end
		ov_nxt = ov_r;
		if (filt_r[P_OV_TRIP]) begin
			ov_nxt = 1'b1;
		end else if (filt_r[P_OV_REL]) begin
			ov_nxt = 1'b0;
		end
		ref_int_nxt = ref_int_r;
		if (filt_r[P_CTRL_HI]) begin
			ref_int_nxt = 1'b1;
		end else if (filt_r[P_CTRL_LO]) begin
			ref_int_nxt = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			therm_r <= 1'b0;
			ov_r <= 1'b0;
			ref_int_r <= REF_INT_RST;
		end else begin
			therm_r <= therm_nxt;
			ov_r <= ov_nxt;
			ref_int_r <= ref_int_nxt;
		end
	end

	// boost short qualification and hiccup sequencing
	hiccup_state_t state_r;
	hiccup_state_t state_nxt;
	logic [QUAL_W-1:0] qual_r;
	logic [QUAL_W-1:0] qual_nxt;
	logic [TICK_W-1:0] hic_r;
	logic [TICK_W-1:0] hic_nxt;
	logic [RETRY_W-1:0] retry_r;
	logic [RETRY_W-1:0] retry_nxt;
	logic seen_r;
	logic seen_nxt;
	logic boost_flt_r;
	logic boost_flt_nxt;
	logic boost_short;
	logic qualified;

	// no hiccup option, no boost short watch
	assign boost_short = HICCUP_EN && !mode_bb && filt_r[P_BOOST_SHORT];
	assign qualified = qual_r == QUAL_W'(QUAL_CYC);

	always_comb begin
		state_nxt = state_r;
		hic_nxt = hic_r;
		retry_nxt = retry_r;
		seen_nxt = seen_r;
		boost_flt_nxt = boost_flt_r;
		// continuous short time, cleared while hiccuping
		if (!boost_short || state_r == ST_HICCUP) begin
			qual_nxt = '0;
		end else if (qualified) begin
			qual_nxt = qual_r;
		end else begin
			qual_nxt = qual_r + QUAL_W'(1);
		end
		case (state_r)
			ST_RUN: begin
				if (qualified) begin
					state_nxt = ST_HICCUP;
					hic_nxt = '0;
					boost_flt_nxt = 1'b1;
				end
			end
			ST_HICCUP: begin
				if (tick_r) begin
					if (hic_r == TICK_W'(HICCUP_TICKS - 1)) begin
						state_nxt = ST_RETRY;
						retry_nxt = '0;
						seen_nxt = 1'b0;
					end else begin
						hic_nxt = hic_r + TICK_W'(1);
					end
				end
			end
			ST_RETRY: begin
				if (qualified) begin
					state_nxt = ST_HICCUP;
					hic_nxt = '0;
				end else if (retry_r == RETRY_W'(RETRY_CYC - 1)) begin
					retry_nxt = '0;
					seen_nxt = 1'b0;
					if (!(seen_r || boost_short)) begin
						boost_flt_nxt = 1'b0;
						state_nxt = ST_RUN;
					end
				end else begin
					retry_nxt = retry_r + RETRY_W'(1);
					seen_nxt = seen_r | boost_short;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state_r <= ST_RUN;
			qual_r <= '0;
			hic_r <= '0;
			retry_r <= '0;
			seen_r <= 1'b0;
			boost_flt_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			qual_r <= qual_nxt;
			hic_r <= hic_nxt;
			retry_r <= retry_nxt;
			seen_r <= seen_nxt;
			boost_flt_r <= boost_flt_nxt;
		end
	end

	// buck-boost persistence; counts down whenever not in that mode
	logic bb_flt;

	// flag from supply margin, switching continues
	persist_counter #(
		.W(TICK_W),
		.FULL(PERSIST_TICKS)
	) u_bb_persist (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.tick_i(tick_r),
		.cond_i(mode_bb && filt_r[P_BB_SHORT]),
		.flag_o(bb_flt)
	);

	// output stage
	logic hiccup;
	logic gate_off;
	logic fault;
	logic sw_gate_r;
	logic sw_gate_nxt;
	logic dim_n_r;
	logic dim_n_nxt;
	logic flt_oe_r;
	logic flt_oe_nxt;
	logic flt_drv_r;
	logic ea_r;
	logic ea_nxt;
	logic ref_out_r;
	logic hic_out_r;

	assign hiccup = state_r == ST_HICCUP;
	assign gate_off = therm_r | ov_r | hiccup | ~dim_on;
	assign fault = therm_r | ov_r | boost_flt_r | bb_flt;

	always_comb begin
		sw_gate_nxt = pwm_req & ~gate_off;
		dim_n_nxt = gate_off;
		ea_nxt = dim_on & ~hiccup;
		flt_oe_nxt = ~fault;
	end

	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			sw_gate_r <= 1'b0;
			dim_n_r <= 1'b1;
			ea_r <= 1'b0;
			flt_oe_r <= 1'b1;
			flt_drv_r <= 1'b0;
			ref_out_r <= REF_INT_RST;
			hic_out_r <= 1'b0;
		end else begin
			sw_gate_r <= sw_gate_nxt;
			dim_n_r <= dim_n_nxt;
			ea_r <= ea_nxt;
			flt_oe_r <= flt_oe_nxt;
			// open drain only ever drives low
			flt_drv_r <= 1'b0;
			ref_out_r <= ref_int_r;
			hic_out_r <= hiccup;
		end
	end

	assign SWITCH_GATE_DRIVE_O = sw_gate_r;
	assign DIM_GATE_DRIVE_N_O = dim_n_r;
	assign FAULT_INDICATOR_N_O = flt_drv_r;
	assign FAULT_INDICATOR_N_OE_O = flt_oe_r;
	assign EA_CONNECT_O = ea_r;
	assign REF_INTERNAL_O = ref_out_r;
	assign HICCUP_ACTIVE_O = hic_out_r;

endmodule

// ==== verilog/persist_counter.sv ====
`timescale 1ns/100ps
module persist_counter import fault_seq_pkg::*; #(
	parameter int unsigned W = TICK_W,
	parameter int unsigned FULL = PERSIST_TICKS_DEF
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic cond_i,
	output logic flag_o
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic flag_r;
	logic flag_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		flag_nxt = flag_r;
		if (tick_i) begin
			if (cond_i && cnt_r != W'(FULL)) begin
				cnt_nxt = cnt_r + W'(1);
			end else if (!cond_i && cnt_r != '0) begin
				cnt_nxt = cnt_r - W'(1);
			end
		end
		if (cnt_r == W'(FULL)) begin
			flag_nxt = 1'b1;
		end else if (cnt_r == '0) begin
			flag_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			flag_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			flag_r <= flag_nxt;
		end
	end

	assign flag_o = flag_r;

endmodule
